/* File: src/eto_trigger_output.sv */
// How it works
// - lines 31..24 drive a static level, each chosen high or low.
// - line 23 goes high when execution hits a breakpoint.
// - line 22 goes high when a trace-point condition is met.
// - line 21 goes high while trace data is captured or discarded.
// - lines 20..16 each follow their own selectable event.
// - split direction: lines 0..15 inputs, lines 16..31 driven outputs.
// - no output while all lines are inputs or no cable is attached.
// - each pending static setting is low, high or keep current.
// - pending static settings reach the pins only on commit.
// - actual levels on lines 31..24 can be read back.
// - reopening the settings returns all pending values to keep.
// - up to 256 patterns are stored, each appended after the last.
// - a stored pattern loads into pending settings, or is deleted alone.
// - breakpoint line stays high after a hit instead of pulsing.
// - trace-point line is high only in cycles the condition holds.
// - every event output lags its detection by eight cycles.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module eto_trigger_output (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  input wire logic cable_present_i,
  input wire logic brk_hit_i,
  input wire logic exec_start_i,
  input wire logic tp_match_i,
  input wire logic trace_filt_i,
  input wire logic [eto_pkg::ETO_N_EVENTS-1:0] event_i,
  input wire logic [eto_pkg::ETO_N_STATIC-1:0] level_sense_i,
  output logic [15:0] trig_o,
  output logic [15:0] trig_oe_o
);
  import eto_pkg::*;

  eto_store_if sif ();

  logic ack;
  logic req;
  logic wr_en;
  logic rd_en;
  logic [31:0] bemask;
  logic cfg_split;
  logic avail;
  logic [15:0] pend;
  logic [7:0] static_lvl;
  logic [7:0] next_static;
  logic [14:0] evsel;
  logic [4:0] stat;
  logic [4:0] mask;
  logic [4:0] stat_set;
  logic [7:0] pidx;
  logic brk_held;
  logic [4:0] sel_ev;
  logic [7:0] raw_ev;
  logic [7:0] pipe [ETO_DELAY-1];
  logic cmd_wr;
  logic [7:0] cmd;
  logic idx_ok;
  logic refuse;

  // one wait cycle per access, more while a delete shifts the store, lets read data settle in a flop first
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack;
  assign wr_en = avs_write_i & ack;
  assign rd_en = avs_read_i & ack;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack & ~sif.busy;
    end
  end

  assign bemask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] cur,
                                        input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (cur & ~m) | (wd & m);
  endfunction

  assign avail = cfg_split & cable_present_i;

  assign cmd_wr = wr_en && avs_address_i == ETO_OFF_CMD &&
                  avs_byteenable_i[0];
  assign cmd = cmd_wr ? avs_writedata_i[7:0] : 8'h00;
  assign idx_ok = {1'b0, pidx} < sif.count;

  assign sif.add = cmd[ETO_CMD_ADD];
  assign sif.del = cmd[ETO_CMD_DELETE];
  assign sif.idx = pidx;
  assign sif.wdata = pend;

  eto_pattern_store u_store (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .st(sif)
  );

  // configuration, selectors, mask and pattern index
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_split <= ETO_CFG_RST;
      evsel <= ETO_EVSEL_RST;
      mask <= ETO_MASK_RST;
      pidx <= 8'h00;
    end else if (wr_en) begin
      case (avs_address_i)
        ETO_OFF_CFG: begin
          if (avs_byteenable_i[0]) begin
            cfg_split <= avs_writedata_i[ETO_CFG_SPLIT];
          end
        end
        ETO_OFF_EVSEL: begin
          evsel <= 15'(merge({17'h00000, evsel}, avs_writedata_i, bemask));
        end
        ETO_OFF_MASK: begin
          mask <= 5'(merge({27'h0000000, mask}, avs_writedata_i, bemask));
        end
        ETO_OFF_PIDX: begin
          if (avs_byteenable_i[0]) begin
            pidx <= avs_writedata_i[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  // pending settings: two bits per static line, bit pair 7 is line 31
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend <= ETO_PEND_RST;
    end else if (cmd[ETO_CMD_REOPEN]) begin
      pend <= ETO_PEND_RST;
    end else if (cmd[ETO_CMD_LOAD] && idx_ok) begin
      pend <= sif.rdata;
    end else if (wr_en && avs_address_i == ETO_OFF_PEND) begin
      pend <= 16'(merge({16'h0000, pend}, avs_writedata_i, bemask));
    end
  end

  genvar g;
  generate
    for (g = 0; g < ETO_N_STATIC; g++) begin : g_static
      always_comb begin
        case (pend[2*g +: 2])
          ETO_LOW: next_static[g] = 1'b0;
          ETO_HIGH: next_static[g] = 1'b1;
          default: next_static[g] = static_lvl[g];
        endcase
      end
    end
    for (g = 0; g < ETO_N_EVSEL; g++) begin : g_evsel
      assign sel_ev[g] = event_i[evsel[g*ETO_EVSEL_W +: ETO_EVSEL_W]];
    end
    for (g = 1; g < ETO_DELAY - 1; g++) begin : g_pipe
      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          pipe[g] <= 8'h00;
        end else begin
          pipe[g] <= pipe[g-1];
        end
      end
    end
  endgenerate

  // commit is ignored while the cable cannot drive
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      static_lvl <= ETO_STATIC_RST;
    end else if (cmd[ETO_CMD_COMMIT] && avail) begin
      static_lvl <= next_static;
    end
  end

  // breakpoint level holds until the next run starts; a hit wins
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      brk_held <= 1'b0;
    end else if (brk_hit_i) begin
      brk_held <= 1'b1;
    end else if (exec_start_i) begin
      brk_held <= 1'b0;
    end
  end

  always_comb begin
    raw_ev = 8'h00;
    raw_ev[ETO_LN_BRK] = brk_held | brk_hit_i;
    raw_ev[ETO_LN_TP] = tp_match_i;
    raw_ev[ETO_LN_TRC] = trace_filt_i;
    raw_ev[4:0] = sel_ev;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pipe[0] <= 8'h00;
    end else begin
      pipe[0] <= raw_ev;
    end
  end

  // output flop is the eighth stage of the event delay
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trig_o <= 16'h0000;
      trig_oe_o <= 16'h0000;
    end else begin
      trig_o <= avail ? {static_lvl, pipe[ETO_DELAY-2]} : 16'h0000;
      trig_oe_o <= avail ? 16'hFFFF : 16'h0000;
    end
  end

  assign refuse = (cmd[ETO_CMD_ADD] && sif.count == ETO_CNT_MAX) ||
                  (cmd[ETO_CMD_COMMIT] && !avail) ||
                  ((cmd[ETO_CMD_LOAD] || cmd[ETO_CMD_DELETE]) && !idx_ok);

  always_comb begin
    stat_set = 5'h00;
    stat_set[ETO_ST_BRK] = brk_hit_i;
    stat_set[ETO_ST_TP] = tp_match_i;
    stat_set[ETO_ST_TRC] = trace_filt_i;
    stat_set[ETO_ST_EVT] = |sel_ev;
    stat_set[ETO_ST_REFUSE] = refuse;
  end

  // read clears only the bits already latched into read data, so an event
  // landing between the data load and the clear is not lost
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stat <= ETO_STAT_RST;
    end else if (rd_en && avs_address_i == ETO_OFF_STAT) begin
      stat <= (stat & ~avs_readdata_o[4:0]) | stat_set;
    end else begin
      stat <= stat | stat_set;
    end
  end

  assign irq_o = |(stat & mask);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && !ack) begin
      case (avs_address_i)
        ETO_OFF_CFG: avs_readdata_o <= {31'h00000000, cfg_split};
        ETO_OFF_PEND: avs_readdata_o <= {16'h0000, pend};
        ETO_OFF_LEVEL: avs_readdata_o <= {24'h000000, level_sense_i};
        ETO_OFF_EVSEL: avs_readdata_o <= {17'h00000, evsel};
        ETO_OFF_STAT: avs_readdata_o <= {27'h0000000, stat};
        ETO_OFF_MASK: avs_readdata_o <= {27'h0000000, mask};
        ETO_OFF_PIDX: avs_readdata_o <= {24'h000000, pidx};
        ETO_OFF_PDATA: avs_readdata_o <= {16'h0000, sif.rdata};
        ETO_OFF_PCNT: avs_readdata_o <= {23'h000000, sif.count};
        default: avs_readdata_o <= 32'h00000000;
      endcase
    end
  end
endmodule // eto_trigger_output

/* File: pkg/eto_pkg.sv */
package eto_pkg;
  localparam int unsigned ETO_AW = 6;
  localparam logic [5:0] ETO_OFF_CFG = 6'h00;
  localparam logic [5:0] ETO_OFF_PEND = 6'h04;
  localparam logic [5:0] ETO_OFF_CMD = 6'h08;
  localparam logic [5:0] ETO_OFF_LEVEL = 6'h0C;
  localparam logic [5:0] ETO_OFF_EVSEL = 6'h10;
  localparam logic [5:0] ETO_OFF_STAT = 6'h14;
  localparam logic [5:0] ETO_OFF_MASK = 6'h18;
  localparam logic [5:0] ETO_OFF_PIDX = 6'h1C;
  localparam logic [5:0] ETO_OFF_PDATA = 6'h20;
  localparam logic [5:0] ETO_OFF_PCNT = 6'h24;

  localparam int unsigned ETO_CFG_SPLIT = 0;
  localparam logic ETO_CFG_RST = 1'b0;

  localparam int unsigned ETO_CMD_COMMIT = 0;
  localparam int unsigned ETO_CMD_REOPEN = 1;
  localparam int unsigned ETO_CMD_ADD = 2;
  localparam int unsigned ETO_CMD_LOAD = 3;
  localparam int unsigned ETO_CMD_DELETE = 4;

  localparam logic [1:0] ETO_KEEP = 2'h0;
  localparam logic [1:0] ETO_LOW = 2'h1;
  localparam logic [1:0] ETO_HIGH = 2'h2;

  localparam int unsigned ETO_N_STATIC = 8;
  localparam int unsigned ETO_PAT_W = 16;
  localparam logic [15:0] ETO_PEND_RST = 16'h0000;
  localparam logic [7:0] ETO_STATIC_RST = 8'h00;

  localparam int unsigned ETO_N_EVSEL = 5;
  localparam int unsigned ETO_EVSEL_W = 3;
  localparam int unsigned ETO_N_EVENTS = 8;
  localparam logic [14:0] ETO_EVSEL_RST = 15'h0000;

  localparam int unsigned ETO_DELAY = 8;
  localparam int unsigned ETO_DEPTH = 256;
  localparam int unsigned ETO_IDX_W = 8;
  localparam int unsigned ETO_CNT_W = 9;
  localparam logic [8:0] ETO_CNT_MAX = 9'h100;

  localparam int unsigned ETO_ST_BRK = 0;
  localparam int unsigned ETO_ST_TP = 1;
  localparam int unsigned ETO_ST_TRC = 2;
  localparam int unsigned ETO_ST_EVT = 3;
  localparam int unsigned ETO_ST_REFUSE = 4;
  localparam int unsigned ETO_ST_W = 5;
  localparam logic [4:0] ETO_STAT_RST = 5'h00;
  localparam logic [4:0] ETO_MASK_RST = 5'h00;

  localparam int unsigned ETO_LN_BRK = 7;
  localparam int unsigned ETO_LN_TP = 6;
  localparam int unsigned ETO_LN_TRC = 5;
endpackage

/* File: pkg/eto_store_if.sv */
`timescale 1ns/1ps
interface eto_store_if;
  logic add;
  logic del;
  logic [7:0] idx;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [8:0] count;
  logic busy;
  modport ctl (output add, output del, output idx, output wdata,
               input rdata, input count, input busy);
  modport store (input add, input del, input idx, input wdata,
                 output rdata, output count, output busy);
endinterface

/* File: src/eto_pattern_store.sv */
`timescale 1ns/1ps
module eto_pattern_store (
  input wire logic mclk_i,
  input wire logic rstn_i,
  eto_store_if.store st
);
  import eto_pkg::*;

  typedef enum logic {ETO_SIDLE, ETO_SSHIFT} eto_store_e;

  logic [15:0] mem [ETO_DEPTH];
  logic [8:0] count;
  logic [7:0] ptr;
  eto_store_e state;

  assign st.rdata = mem[st.idx];
  assign st.count = count;
  assign st.busy = (state == ETO_SSHIFT);

  // delete closes the gap one entry per cycle; bus waits meanwhile
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ETO_SIDLE;
      count <= 9'h000;
      ptr <= 8'h00;
    end else begin
      case (state)
        ETO_SIDLE: begin
          if (st.add && count < ETO_CNT_MAX) begin
            count <= count + 9'h001;
          end else if (st.del && {1'b0, st.idx} < count) begin
            if ({1'b0, st.idx} == count - 9'h001) begin
              count <= count - 9'h001;
            end else begin
              ptr <= st.idx;
              state <= ETO_SSHIFT;
            end
          end
        end
        ETO_SSHIFT: begin
          ptr <= ptr + 8'h01;
          if ({1'b0, ptr} + 9'h002 == count) begin
            count <= count - 9'h001;
            state <= ETO_SIDLE;
          end
        end
        default: state <= ETO_SIDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (state == ETO_SIDLE && st.add && count < ETO_CNT_MAX) begin
      mem[count[7:0]] <= st.wdata;
    end else if (state == ETO_SSHIFT) begin
      mem[ptr] <= mem[ptr + 8'h01];
    end
  end
endmodule // eto_pattern_store

/* File: testbench/eto_trigger_output_asserts.sv */
`timescale 1ns/1ps
module eto_trigger_output_asserts (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic cable_present_i,
  input wire logic brk_hit_i,
  input wire logic tp_match_i,
  input wire logic trace_filt_i,
  input wire logic [15:0] trig_o,
  input wire logic [15:0] trig_oe_o
);
  import eto_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // eight cycles of output available: the whole pipeline saw a live cable
  sequence up8;
    (cable_present_i && trig_oe_o[0]) [*8];
  endsequence
  oe_shape_a: assert property (trig_oe_o == 16'h0000 ||
    trig_oe_o == 16'hFFFF) else $error("oe not uniform");
  cable_off_a: assert property (!cable_present_i |=>
    trig_oe_o == 16'h0000 && trig_o == 16'h0000) else $error("drive no cable");
  brk_on_a: assert property (brk_hit_i ##1 up8 |->
    trig_o[ETO_LN_BRK]) else $error("brk line low");
  tp_on_a: assert property (tp_match_i ##1 up8 |->
    trig_o[ETO_LN_TP]) else $error("tp line low");
  tp_off_a: assert property (!tp_match_i ##1 up8 |->
    !trig_o[ETO_LN_TP]) else $error("tp line high");
  trc_on_a: assert property (trace_filt_i ##1 up8 |->
    trig_o[ETO_LN_TRC]) else $error("trace line low");
  trc_off_a: assert property (!trace_filt_i ##1 up8 |->
    !trig_o[ETO_LN_TRC]) else $error("trace line high");
  static_hold_a: assert property (trig_oe_o[0] &&
    $past(trig_oe_o[0]) && trig_o[15:8] != $past(trig_o[15:8]) |->
    $past(avs_write_i && !avs_waitrequest_o && avs_address_i == ETO_OFF_CMD)
    || $past(avs_write_i && !avs_waitrequest_o &&
    avs_address_i == ETO_OFF_CMD, 2)) else $error("static moved");
  rst_zero_a: assert property ($rose(rstn_i) |->
    trig_o == 16'h0000 && trig_oe_o == 16'h0000) else $error("not low");
endmodule // eto_trigger_output_asserts

/* File: testbench/eto_target_model.sv */
`timescale 1ns/1ps
module eto_target_model (
  input wire logic mclk_i,
  input wire logic [15:0] trig_o,
  input wire logic [15:0] trig_oe_o,
  output logic [7:0] level_o
);
  logic [7:0] last = 8'h00;
  always @(posedge mclk_i) begin
    if (trig_oe_o[8]) last <= trig_o[15:8];
  end
  // released lines float: show the inverse so a stale level never passes
  assign level_o = trig_oe_o[8] ? trig_o[15:8] : ~last;
endmodule // eto_target_model

/* File: testbench/eto_trigger_output_bench.sv */
`timescale 1ns/1ps
module eto_trigger_output_bench;
  import eto_pkg::*;
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
  logic mclk_i = 1'b0, rstn_i = 1'b0, rd = 1'b0, wr = 1'b0, wait_o, irq;
  logic cable = 1'b1, brk = 1'b0, exs = 1'b0, tp = 1'b0, trc = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [7:0] ev = 8'h00, lvl;
  logic [15:0] trig_o, trig_oe_o;
  int fail_count = 0, checks = 0;
  always #4 mclk_i = ~mclk_i;
  eto_trigger_output eto_trigger_output_i (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_o), .irq_o(irq), .cable_present_i(cable),
    .brk_hit_i(brk), .exec_start_i(exs), .tp_match_i(tp),
    .trace_filt_i(trc), .event_i(ev), .level_sense_i(lvl),
    .trig_o(trig_o), .trig_oe_o(trig_oe_o));
  eto_target_model eto_target_model_i (.mclk_i(mclk_i), .trig_o(trig_o),
    .trig_oe_o(trig_oe_o), .level_o(lvl));
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    // look at waitrequest once settled, then complete on the rising edge
    @(negedge mclk_i);
    while (wait_o !== 1'b0 && n < 400) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 400) begin
      fail_count++;
      close_out();
    end
    @(posedge mclk_i);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, q)
  endtask
  initial begin
    cyc(5);
    rstn_i <= 1'b1;
    `CHK("trig", 16'h0000, trig_o)
    rchk("cfg", ETO_OFF_CFG, 32'h0);
    bus(1'b1, ETO_OFF_CMD, 32'h1);
    rchk("stat", ETO_OFF_STAT, 32'h10);
    rchk("unmapped", 6'h3C, 32'h0);
    bus(1'b1, ETO_OFF_CFG, 32'h1);
    cyc(2);
    `CHK("oe", 16'hFFFF, trig_oe_o)
    cable <= 1'b0;
    cyc(2);
    `CHK("oe", 16'h0000, trig_oe_o)
    cable <= 1'b1;
    $display("test setup done");
    bus(1'b1, ETO_OFF_PEND, 32'h8006);
    cyc(3);
    `CHK("static", 8'h00, trig_o[15:8])
    bus(1'b1, ETO_OFF_CMD, 32'h1);
    cyc(3);
    `CHK("static", 8'h81, trig_o[15:8])
    rchk("level", ETO_OFF_LEVEL, 32'h81);
    bus(1'b1, ETO_OFF_PEND, 32'h0023);
    bus(1'b1, ETO_OFF_CMD, 32'h1);
    cyc(3);
    `CHK("static", 8'h85, trig_o[15:8])
    bus(1'b1, ETO_OFF_CMD, 32'h2);
    rchk("pend", ETO_OFF_PEND, 32'h0);
    bus(1'b1, ETO_OFF_CMD, 32'h1);
    cyc(3);
    `CHK("static", 8'h85, trig_o[15:8])
    $display("test static done");
    bus(1'b1, ETO_OFF_PEND, 32'h8006);
    bus(1'b1, ETO_OFF_CMD, 32'h4);
    bus(1'b1, ETO_OFF_PEND, 32'h0020);
    bus(1'b1, ETO_OFF_CMD, 32'h4);
    rchk("pcnt", ETO_OFF_PCNT, 32'h2);
    bus(1'b1, ETO_OFF_PIDX, 32'h1);
    rchk("pdata", ETO_OFF_PDATA, 32'h20);
    bus(1'b1, ETO_OFF_PIDX, 32'h0);
    bus(1'b1, ETO_OFF_CMD, 32'h8);
    rchk("pend", ETO_OFF_PEND, 32'h8006);
    bus(1'b1, ETO_OFF_CMD, 32'h10);
    rchk("pcnt", ETO_OFF_PCNT, 32'h1);
    rchk("pdata", ETO_OFF_PDATA, 32'h20);
    bus(1'b1, ETO_OFF_PIDX, 32'h5);
    bus(1'b1, ETO_OFF_CMD, 32'h8);
    rchk("stat", ETO_OFF_STAT, 32'h10);
    repeat (255) bus(1'b1, ETO_OFF_CMD, 32'h4);
    bus(1'b1, ETO_OFF_CMD, 32'h4);
    rchk("stat", ETO_OFF_STAT, 32'h10);
    rchk("pcnt", ETO_OFF_PCNT, 32'h100);
    bus(1'b1, ETO_OFF_PIDX, 32'h0);
    bus(1'b1, ETO_OFF_CMD, 32'h10);
    rchk("pcnt", ETO_OFF_PCNT, 32'hFF);
    $display("test store done");
    bus(1'b1, ETO_OFF_MASK, 32'h2);
    @(posedge mclk_i);
    tp <= 1'b1;
    @(posedge mclk_i);
    tp <= 1'b0;
    cyc(10);
    `CHK("irq", 1'b1, irq)
    rchk("stat", ETO_OFF_STAT, 32'h2);
    cyc(1);
    `CHK("irq", 1'b0, irq)
    trc <= 1'b1;
    cyc(3);
    trc <= 1'b0;
    cyc(10);
    rchk("stat", ETO_OFF_STAT, 32'h4);
    brk <= 1'b1;
    cyc(1);
    brk <= 1'b0;
    cyc(20);
    `CHK("brk", 1'b1, trig_o[ETO_LN_BRK])
    exs <= 1'b1;
    cyc(1);
    exs <= 1'b0;
    cyc(12);
    `CHK("brk", 1'b0, trig_o[ETO_LN_BRK])
    bus(1'b1, ETO_OFF_EVSEL, 32'h5003);
    ev <= 8'h08;
    cyc(10);
    `CHK("evt", 5'h01, trig_o[4:0])
    ev <= 8'h20;
    cyc(10);
    `CHK("evt", 5'h10, trig_o[4:0])
    ev <= 8'h00;
    $display("test events done");
    close_out();
  end
endmodule // eto_trigger_output_bench
bind eto_trigger_output eto_trigger_output_asserts eto_trigger_output_asserts_i (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .cable_present_i(cable_present_i), .brk_hit_i(brk_hit_i),
  .tp_match_i(tp_match_i), .trace_filt_i(trace_filt_i), .trig_o(trig_o),
  .trig_oe_o(trig_oe_o));
